// ===== rtl/thcc_pkg.sv
/*
  package of the thermal channel configuration bank: register offsets, field positions,
  reset values and identification defaults.
  assumes an 8-bit register address space reached by a management bus front end.
*/
package thcc_pkg;
  localparam int          THCC_CHANNELS       = 8;
  localparam logic [7:0]  THCC_OFS_CORR_DIS   = 8'h39;
  localparam logic [7:0]  THCC_OFS_HOT_SEL    = 8'h3A;
  localparam logic [7:0]  THCC_OFS_CH_SETUP   = 8'h3B;
  localparam logic [7:0]  THCC_OFS_AVG_CTRL   = 8'h40;
  localparam logic [7:0]  THCC_OFS_PART       = 8'hFD;
  localparam logic [7:0]  THCC_OFS_MAKER      = 8'hFE;
  localparam logic [7:0]  THCC_OFS_REV        = 8'hFF;
  localparam logic [7:0]  THCC_RST_CFG        = 8'h00;
  localparam logic [7:0]  THCC_MASK_EXT       = 8'hFE;
  localparam logic [7:0]  THCC_MASK_SETUP     = 8'h8E;
  localparam int          THCC_BIT_WATCH      = 7;
  localparam int          THCC_BIT_PAIR6      = 3;
  localparam int          THCC_BIT_PAIR4      = 2;
  localparam int          THCC_BIT_PAIR2      = 1;
  localparam int          THCC_BIT_INT        = 0;
  localparam logic [7:0]  THCC_NO_HOT_HIGH    = 8'h80;
  localparam logic [7:0]  THCC_UNMAPPED_READ  = 8'h00;
  // identification codes: arbitrary neutral values
  localparam logic [7:0]  THCC_PART_DEF       = 8'hA5;
  localparam logic [7:0]  THCC_MAKER_DEF      = 8'h3C;
  localparam logic [7:0]  THCC_REV_DEF        = 8'h02;
endpackage : thcc_pkg

// ===== rtl/thcc_avg4.sv
/*
  per-channel 4x running average over the last four readings, with bypass.
  assumes sample_vld marks a new reading for this channel; readings are unsigned codes.
*/
`timescale 1ns/100ps
`default_nettype none
module thcc_avg4 #(
  parameter int W = 11
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         avg_en,
  input  wire logic         sample_vld,
  input  wire logic [W-1:0] sample,
  output logic      [W-1:0] result
);
  typedef struct packed {
    logic [3:0][W-1:0] hist;
    logic [W-1:0]      res;
  } thcc_avg_t;
  thcc_avg_t st_r;
  thcc_avg_t st_nxt;
  logic [W+1:0] sum;

  initial begin
    if (W < 2) $error("thcc_avg4: width too small");
  end

  always_comb begin
    st_nxt = st_r;
    sum    = {2'b00, sample} + {2'b00, st_r.hist[0]} + {2'b00, st_r.hist[1]}
           + {2'b00, st_r.hist[2]};
    if (sample_vld) begin
      st_nxt.hist = {st_r.hist[2:0], sample};
      // averaging off gives the raw reading
      st_nxt.res  = avg_en ? sum[W+1:2] : sample;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) st_r <= '0;
    else      st_r <= st_nxt;
  end

  assign result = st_r.res;
endmodule : thcc_avg4
`default_nettype wire

// ===== rtl/thcc_top.sv
/*
  configuration and identification bank of a multi-channel diode temperature monitor,
  with hottest-of comparison, change watch, anti-parallel pair enables and averaging.
  assumes the bus front end gives single-cycle reg_wr/reg_rd strobes with an 8-bit address,
  and that the conversion engine presents one reading per channel with a strobe.
*/
// Notes on behaviour
// - channel bit one disables resistance error correction; zero keeps it on
// - end of conversion compares only selected, active channels for hottest
// - internal channel joins comparison only when select bit zero is one
// - watch bit on: flag when hottest channel differs from last remembered
// - pair-six bit on monitors channels six and seven, else six only
// - pair-four bit on monitors channels four and five, else four only
// - pair-two bit on monitors channels two and three, else two only
// - averaging bit one reports running mean of last four readings
// - three fixed read-only identity bytes at the top three addresses
// - nothing selected makes hottest high byte read sign-only value
// - ties resolve to the earliest channel in measurement order
`timescale 1ns/100ps
`default_nettype none
module thcc_top
  import thcc_pkg::*;
#(
  parameter int         TEMP_W   = 11,
  parameter logic [7:0] PART_ID  = THCC_PART_DEF,
  parameter logic [7:0] MAKER_ID = THCC_MAKER_DEF,
  parameter logic [7:0] REV_ID   = THCC_REV_DEF
) (
  input  wire logic                            clk_sys,
  input  wire logic                            srst,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [7:0]                      reg_wdata,
  output logic      [7:0]                      reg_rdata,
  input  wire logic                            sample_vld,
  input  wire logic [THCC_CHANNELS-1:0][TEMP_W-1:0] sample_temp,
  input  wire logic                            conv_done,
  input  wire logic                            hot_flag_clr,
  output logic      [THCC_CHANNELS-1:0][TEMP_W-1:0] reported_temp,
  output logic      [6:0]                      correction_off,
  output logic      [THCC_CHANNELS-1:0]        channel_active,
  output logic      [TEMP_W-1:0]               hottest_temp,
  output logic      [7:0]                      hottest_high,
  output logic      [7:0]                      hottest_status,
  output logic                                 hottest_change_flag
);
  typedef struct packed {
    logic [7:0]  corr_dis;
    logic [7:0]  hot_sel;
    logic [7:0]  ch_setup;
    logic [7:0]  avg_ctrl;
    logic [7:0]  rdata;
    logic [7:0]  hot_stat;
    logic [7:0]  last_hot;
    logic        have_last;
    logic        chg_flag;
    logic [TEMP_W-1:0] hot_temp;
    logic        none_sel;
  } thcc_state_t;

  thcc_state_t st_r;
  thcc_state_t st_nxt;
  logic [THCC_CHANNELS-1:0] cmp_en;
  logic [THCC_CHANNELS-1:0] act;
  logic [7:0]               pick;
  logic [TEMP_W-1:0]        best;
  logic                     found;
  logic [7:0]               rd_mux;

  initial begin
    if (TEMP_W < 8) $error("thcc_top: TEMP_W must be at least 8");
  end

  // averaging per channel, internal channel never averaged
  genvar g;
  generate
    for (g = 0; g < THCC_CHANNELS; g++) begin : g_ch
      thcc_avg4 #(.W(TEMP_W)) u_avg (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .avg_en    ((g == 0) ? 1'b0 : st_r.avg_ctrl[g]),
        .sample_vld(sample_vld),
        .sample    (sample_temp[g]),
        .result    (reported_temp[g])
      );
    end
  endgenerate

  always_comb begin
    act = '1;
    act[3] = st_r.ch_setup[THCC_BIT_PAIR2];
    act[5] = st_r.ch_setup[THCC_BIT_PAIR4];
    act[7] = st_r.ch_setup[THCC_BIT_PAIR6];
    // external select bits, internal bit zero
    cmp_en = st_r.hot_sel & act;
    pick  = '0;
    best  = '0;
    found = 1'b0;
    // strict greater keeps the earlier channel on a tie
    for (int i = 0; i < THCC_CHANNELS; i++) begin
      if (cmp_en[i] && (!found || (reported_temp[i] > best))) begin
        best  = reported_temp[i];
        pick  = 8'h01 << i;
        found = 1'b1;
      end
    end
  end

  always_comb begin
    unique case (reg_addr)
      THCC_OFS_CORR_DIS: rd_mux = st_r.corr_dis;
      THCC_OFS_HOT_SEL:  rd_mux = st_r.hot_sel;
      THCC_OFS_CH_SETUP: rd_mux = st_r.ch_setup;
      THCC_OFS_AVG_CTRL: rd_mux = st_r.avg_ctrl;
      THCC_OFS_PART:     rd_mux = PART_ID;
      THCC_OFS_MAKER:    rd_mux = MAKER_ID;
      THCC_OFS_REV:      rd_mux = REV_ID;
      default:           rd_mux = THCC_UNMAPPED_READ;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (reg_rd) st_nxt.rdata = rd_mux;
    if (reg_wr) begin
      unique case (reg_addr)
        THCC_OFS_CORR_DIS: st_nxt.corr_dis = reg_wdata & THCC_MASK_EXT;
        THCC_OFS_HOT_SEL:  st_nxt.hot_sel  = reg_wdata;
        THCC_OFS_CH_SETUP: st_nxt.ch_setup = reg_wdata & THCC_MASK_SETUP;
        THCC_OFS_AVG_CTRL: st_nxt.avg_ctrl = reg_wdata & THCC_MASK_EXT;
        default: ;
      endcase
    end
    // clear first so a same-cycle change event wins
    if (hot_flag_clr) st_nxt.chg_flag = 1'b0;
    if (conv_done) begin
      st_nxt.hot_stat = pick;
      st_nxt.hot_temp = found ? best : '0;
      st_nxt.none_sel = !found;
      if (found) begin
        if (st_r.ch_setup[THCC_BIT_WATCH] && st_r.have_last && (pick != st_r.last_hot))
          st_nxt.chg_flag = 1'b1;
        st_nxt.last_hot  = pick;
        st_nxt.have_last = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r           <= '0;
      st_r.corr_dis  <= THCC_RST_CFG;
      st_r.hot_sel   <= THCC_RST_CFG;
      st_r.ch_setup  <= THCC_RST_CFG;
      st_r.avg_ctrl  <= THCC_RST_CFG;
      st_r.none_sel  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata           = st_r.rdata;
  assign correction_off      = st_r.corr_dis[7:1];
  assign channel_active      = act;
  assign hottest_temp        = st_r.hot_temp;
  assign hottest_high        = st_r.none_sel ? THCC_NO_HOT_HIGH
                                             : st_r.hot_temp[TEMP_W-1 -: 8];
  assign hottest_status      = st_r.hot_stat;
  assign hottest_change_flag = st_r.chg_flag;
endmodule : thcc_top
`default_nettype wire

// ===== test/thcc_cfg_chk.sv
/*
  port checker of the thermal channel configuration bank.
  assumes it is bound to thcc_top and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module thcc_cfg_chk
  import thcc_pkg::*;
#(
  parameter int         TEMP_W  = 11,
  parameter logic [7:0] PART_ID = THCC_PART_DEF
) (
  input wire logic                     clk_sys,
  input wire logic                     srst,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     conv_done,
  input wire logic                     hot_flag_clr,
  input wire logic [6:0]               correction_off,
  input wire logic [THCC_CHANNELS-1:0] channel_active,
  input wire logic [TEMP_W-1:0]        hottest_temp,
  input wire logic [7:0]               hottest_high,
  input wire logic [7:0]               hottest_status,
  input wire logic                     hottest_change_flag
);
  logic [7:0] wd_q;
  always_ff @(posedge clk_sys) wd_q <= reg_wdata;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_corr_map: assert property (reg_wr && !reg_rd && reg_addr == 8'h39
    |=> correction_off == wd_q[7:1]) else $error("correction outputs wrong");
  chk_id_part: assert property (reg_rd && reg_addr == 8'hFD
    |=> reg_rdata == PART_ID) else $error("part code wrong");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_fixed_active: assert property (&{channel_active[0], channel_active[1],
    channel_active[2], channel_active[4], channel_active[6]}) else $error("lane inactive");
  chk_pair_two: assert property (reg_wr && reg_addr == 8'h3B
    |=> channel_active[3] == wd_q[1]) else $error("pair two lane wrong");
  chk_none_high: assert property (hottest_status == 8'h00
    |-> hottest_high == 8'h80) else $error("empty high byte wrong");
  chk_high_byte: assert property (hottest_status != 8'h00
    |-> hottest_high == hottest_temp[TEMP_W-1:TEMP_W-8]) else $error("high byte wrong");
  chk_one_winner: assert property ($onehot0(hottest_status))
    else $error("several winners");
  chk_status_hold: assert property (!conv_done |=> $stable(hottest_status))
    else $error("status moved without conversion");
  chk_flag_sticky: assert property (hottest_change_flag && !hot_flag_clr
    |=> hottest_change_flag) else $error("change flag dropped");
endmodule : thcc_cfg_chk
`default_nettype wire

// ===== test/thcc_conv_model.sv
/*
  conversion engine model: on go it gives one set of readings, then end of conversion.
  assumes go is a one-cycle pulse and the next go waits for the cycle to end.
*/
`timescale 1ns/100ps
`default_nettype none
module thcc_conv_model (
  input  wire logic clk_sys,
  input  wire logic go,
  output logic      sample_vld,
  output logic      conv_done
);
  logic gap_r;
  initial {sample_vld, gap_r, conv_done} = 3'h0;
  // a spare cycle so the reading has settled before the compare
  always @(posedge clk_sys) begin
    sample_vld <= go;
    gap_r      <= sample_vld;
    conv_done  <= gap_r;
  end
endmodule : thcc_conv_model
`default_nettype wire

// ===== test/tb_top.sv
/*
  self-checking bench of thcc_top with the conversion model.
  assumes nothing beyond the package constants and default identity codes.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import thcc_pkg::*;
  logic clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, go = 0, clr = 0, sv, cd;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, hi, st;
  logic [THCC_CHANNELS-1:0][10:0] tmp = '0, rep;
  logic [6:0] coff;
  logic flag;
  int n_errors = 0, n_compared = 0;
  logic [23:0] rows [8] = '{24'h39FFFE, 24'h3AFFFF, 24'h3BFF8E, 24'h40FFFE,
                            24'hFD00A5, 24'hFE113C, 24'hFF2202, 24'h005500};
  always #20 clk_sys = ~clk_sys;
  thcc_conv_model i_conv (.clk_sys(clk_sys), .go(go), .sample_vld(sv), .conv_done(cd));
  thcc_top i_dut (.clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdat), .reg_rdata(rdat), .sample_vld(sv),
    .sample_temp(tmp), .conv_done(cd), .hot_flag_clr(clr), .reported_temp(rep),
    .correction_off(coff), .channel_active(), .hottest_temp(), .hottest_high(hi),
    .hottest_status(st), .hottest_change_flag(flag));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) {reg_wr, reg_rd, addr, wdat} <= {w, !w, a, d};
    @(posedge clk_sys) {reg_wr, reg_rd} <= 2'b00;
    @(negedge clk_sys);
  endtask : acc
  task automatic conv(input int k, input logic [10:0] t, input int m, input logic [10:0] u);
    logic [THCC_CHANNELS-1:0][10:0] v;
    v = {8{11'd100}};
    v[k] = t;
    v[m] = u;
    @(posedge clk_sys) begin
      tmp <= v;
      go  <= 1'b1;
    end
    @(posedge clk_sys) go <= 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : conv
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    // write then read back each row; unused bits and read-only places
    foreach (rows[i]) begin
      acc(1, rows[i][23:16], rows[i][15:8]);
      acc(0, rows[i][23:16], 8'h00);
      check(rdat, rows[i][7:0]);
    end
    check(coff, 7'h7F);
    // first readings average against a zero history
    conv(3, 11'd500, 3, 11'd500);
    check(rep[1], 11'd25);
    check(rep[0], 11'd100);
    check(st, 8'h08);
    check(hi, 8'h0F);
    acc(1, 8'h40, 8'h00);
    conv(5, 11'd500, 5, 11'd500);
    check(st, 8'h20);
    check(flag, 1'b1);
    @(posedge clk_sys) clr <= 1'b1;
    @(posedge clk_sys) clr <= 1'b0;
    @(negedge clk_sys) check(flag, 1'b0);
    conv(6, 11'd600, 2, 11'd600);
    check(st, 8'h04);
    // pair bits off: lanes three, five and seven drop out
    acc(1, 8'h3B, 8'h80);
    conv(7, 11'd700, 6, 11'd650);
    check(st, 8'h40);
    @(posedge clk_sys) clr <= 1'b1;
    @(posedge clk_sys) clr <= 1'b0;
    // watch off, pair two on: lane three wins without raising the flag
    acc(1, 8'h3B, 8'h02);
    conv(3, 11'd700, 2, 11'd650);
    check(st, 8'h08);
    check(flag, 1'b0);
    acc(1, 8'h3A, 8'h00);
    conv(7, 11'd700, 6, 11'd650);
    check(hi, 8'h80);
    @(posedge clk_sys) srst <= 1'b1;
    @(posedge clk_sys) srst <= 1'b0;
    acc(0, 8'h3B, 8'h00);
    check(rdat, 8'h00);
    check(st, 8'h00);
    check(hi, 8'h80);
    check(flag, 1'b0);
    summarize();
  end
endmodule : tb_top
bind thcc_top thcc_cfg_chk #(.TEMP_W(TEMP_W), .PART_ID(PART_ID)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .conv_done(conv_done), .hot_flag_clr(hot_flag_clr), .correction_off(correction_off),
  .channel_active(channel_active), .hottest_temp(hottest_temp),
  .hottest_high(hottest_high), .hottest_status(hottest_status),
  .hottest_change_flag(hottest_change_flag));
`default_nettype wire
